// ### design/cgm_div_if.sv
/*
  cgm_div_if: carries the source tick, divisor select and divided enable between the
  mode control and its bus divider.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface cgm_div_if;
    logic       tick;
    logic [2:0] sel;
    logic       en_out;
    modport src (output tick, output sel, input en_out);
    modport div (input tick, input sel, output en_out);
endinterface : cgm_div_if

// ### design/cgm_mode_ctrl.sv
/*
  cgm_mode_ctrl: mode selection, loop lock tracking, reference watch, loss action, bus
  divider and derived clock enables of the clock generator, with an APB register slave.
  Assumes pclk at 100 MHz; ext_ref_in and stop_req arrive asynchronously and are synchronised.
  The controlled oscillator is modelled as a phase accumulator stepped by the filter value.
*/
`timescale 1ns/1ps
module cgm_mode_ctrl
    import cgm_pkg::*;
#(
    parameter int unsigned RTI_DIV = RTI_DIV_DEF
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        ext_ref_in,
    input  wire logic        stop_req,
    // clock enables
    output logic             generator_output_clock,
    output logic             bus_clk_en,
    output logic             loop_output_clock,
    output logic             ext_reference_clock,
    output logic             fixed_freq_clock,
    output logic             fixed_freq_enable,
    output logic             debug_local_clock,
    output logic             rti_clock,
    // loss action
    output logic             loss_reset,
    output logic             loss_irq
);
    cgm_state_t  state;
    cgm_state_t  next_state;
    cgm_mode_t   mode_req;
    logic [2:0]  div_sel;
    logic        rst_sel;
    logic        locd;
    logic [15:0] filter;
    logic [9:0]  mult;
    logic        locked;
    logic        lost_flag;
    logic        loss_flag;
    logic        ext_valid;
    logic        src_ext;
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;
    logic        stop_meta;
    logic        stop_sync;
    logic [9:0]  ext_wd;
    logic [15:0] dco_acc;
    logic        dco_pulse;
    logic [15:0] dco_cnt;
    logic [2:0]  match_cnt;
    logic        lost_set;
    logic        ff_pending;
    logic        ff_last;
    logic        int_tick;
    logic        dbg_tick;
    logic        rti_tick;
    logic        ext_edge;
    logic        engaged;
    logic        ref_edge;
    logic        clk_loss_set;
    logic        wr_en;
    logic        filter_wr;
    logic [15:0] mult16;
    logic [15:0] abs_err;
    logic [16:0] acc_sum;
    logic [31:0] rd_mux;
    logic        rd_hit;

    cgm_div_if div_if ();

    cgm_tick_div #(.DIV(INT_REF_DIV)) u_int_ref (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (1'b1),
        .tick    (int_tick)
    );
    cgm_tick_div #(.DIV(DEBUG_DIV)) u_debug (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (1'b1),
        .tick    (dbg_tick)
    );
    cgm_tick_div #(.DIV(RTI_DIV)) u_rti (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (1'b1),
        .tick    (rti_tick)
    );
    cgm_pow2_div u_bus_div (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (div_if)
    );

    assign div_if.tick = generator_output_clock;
    assign div_if.sel  = div_sel;
    assign bus_clk_en  = div_if.en_out;

    // apb decode; pready rises in the first access cycle, so every transfer has no wait state
    assign wr_en     = psel && penable && pready && pwrite && !pslverr;
    assign filter_wr = wr_en && (paddr == OFF_FILTER);

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFF_CTRL: begin
                rd_mux[CTRL_MODE_LSB +: 2] = mode_req;
                rd_mux[CTRL_DIV_LSB +: 3]  = div_sel;
                rd_mux[CTRL_RST_SEL]       = rst_sel;
                rd_mux[CTRL_LOCD]          = locd;
            end
            OFF_FILTER: rd_mux[15:0] = filter;
            OFF_MULT:   rd_mux[9:0]  = mult;
            OFF_STATUS: begin
                rd_mux[STAT_LOCK]           = locked;
                rd_mux[STAT_LOST]           = lost_flag;
                rd_mux[STAT_EXTV]           = ext_valid;
                rd_mux[STAT_LOSS]           = loss_flag;
                rd_mux[STAT_STATE_LSB +: 3] = state;
                rd_mux[STAT_SRC]            = src_ext;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_req <= MODE_SELF;
            div_sel  <= DIV_RST;
            rst_sel  <= 1'b0;
            locd     <= 1'b0;
            mult     <= MULT_RST;
        end else if (wr_en && paddr == OFF_CTRL) begin
            mode_req <= cgm_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            div_sel  <= pwdata[CTRL_DIV_LSB +: 3];
            rst_sel  <= pwdata[CTRL_RST_SEL];
            locd     <= pwdata[CTRL_LOCD];
        end else if (wr_en && paddr == OFF_MULT) begin
            mult <= pwdata[9:0];
        end
    end

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta  <= 1'b0;
            ext_sync  <= 1'b0;
            ext_prev  <= 1'b0;
            stop_meta <= 1'b0;
            stop_sync <= 1'b0;
        end else begin
            ext_meta  <= ext_ref_in;
            ext_sync  <= ext_meta;
            ext_prev  <= ext_sync;
            stop_meta <= stop_req;
            stop_sync <= stop_meta;
        end
    end
    assign ext_edge = ext_sync && !ext_prev;

    // reference watchdog: valid on an edge, invalid after a silent timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_wd    <= '0;
            ext_valid <= 1'b0;
        end else if (ext_edge) begin
            ext_wd    <= '0;
            ext_valid <= 1'b1;
        end else if (ext_wd == EXT_TIMEOUT_CYC) begin
            ext_valid <= 1'b0;
        end else begin
            ext_wd <= ext_wd + 1'b1;
        end
    end

    // mode state; a mode needing the external reference waits until it runs
    always_comb begin
        next_state = ST_SELF;
        if (stop_sync) begin
            next_state = ST_OFF;
        end else begin
            unique case (mode_req)
                MODE_SELF:       next_state = ST_SELF;
                MODE_LOOP_INT:   next_state = ST_LOOP_INT;
                MODE_BYPASS_EXT: next_state = ext_valid ? ST_BYPASS : ST_SELF;
                MODE_LOOP_EXT:   next_state = (ext_valid || state == ST_LOOP_EXT) ? ST_LOOP_EXT
                                                                                  : ST_SELF;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state <= ST_SELF;
        else state <= next_state;
    end

    assign engaged  = (state == ST_LOOP_INT) || (state == ST_LOOP_EXT);
    assign ref_edge = (state == ST_LOOP_EXT) ? ext_edge : int_tick;

    // controlled oscillator: halted in off mode, keeps its phase and filter
    assign acc_sum = {1'b0, dco_acc} + {1'b0, filter};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dco_acc   <= '0;
            dco_pulse <= 1'b0;
        end else if (state == ST_OFF) begin
            dco_pulse <= 1'b0;
        end else begin
            dco_acc   <= acc_sum[15:0];
            dco_pulse <= acc_sum[16];
        end
    end

    // frequency measure over one reference period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dco_cnt <= '0;
        else if (ref_edge) dco_cnt <= {15'h0000, dco_pulse};
        else if (dco_pulse) dco_cnt <= dco_cnt + 1'b1;
    end

    assign mult16  = {6'h00, mult};
    assign abs_err = (dco_cnt > mult16) ? dco_cnt - mult16 : mult16 - dco_cnt;

    // filter: software write wins; loop trims only when engaged on a reference edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter <= FILTER_RST;
        end else if (filter_wr) begin
            filter <= pwdata[15:0];
        end else if (engaged && ref_edge && abs_err > LOCK_TOL
                     && (state != ST_LOOP_EXT || ext_valid)) begin
            filter <= (dco_cnt > mult16) ? filter - FILTER_STEP : filter + FILTER_STEP;
        end
    end

    // lock tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_cnt <= '0;
            locked    <= 1'b0;
            lost_set  <= 1'b0;
        end else begin
            lost_set <= 1'b0;
            if (!engaged) begin
                match_cnt <= '0;
                locked    <= 1'b0;
            end else if (ref_edge) begin
                if (abs_err <= LOCK_TOL) begin
                    if (match_cnt == LOCK_MATCHES - 3'h1) locked <= 1'b1;
                    else match_cnt <= match_cnt + 1'b1;
                end else begin
                    match_cnt <= '0;
                    if (locked && abs_err > LOSS_TOL) begin
                        locked   <= 1'b0;
                        lost_set <= 1'b1;
                    end
                end
            end
        end
    end

    // sticky loss flags, write one to clear, a new event beats the clear
    assign clk_loss_set = !locd && ext_wd == EXT_TIMEOUT_CYC && ext_valid
                          && (state == ST_LOOP_EXT || state == ST_BYPASS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_flag <= 1'b0;
            loss_flag <= 1'b0;
        end else begin
            if (lost_set) lost_flag <= 1'b1;
            else if (wr_en && paddr == OFF_STATUS && pwdata[STAT_LOST]) lost_flag <= 1'b0;
            if (clk_loss_set) loss_flag <= 1'b1;
            else if (wr_en && paddr == OFF_STATUS && pwdata[STAT_LOSS]) loss_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_reset <= 1'b0;
            loss_irq   <= 1'b0;
        end else begin
            loss_reset <= rst_sel && (lost_set || clk_loss_set);
            loss_irq   <= !rst_sel && (lost_flag || loss_flag);
        end
    end

    // source select: changes only in a cycle with no pulse on either source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) src_ext <= 1'b0;
        else if (!dco_pulse && !ext_edge) src_ext <= (state == ST_BYPASS);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            generator_output_clock <= 1'b0;
            loop_output_clock      <= 1'b0;
            ext_reference_clock    <= 1'b0;
        end else begin
            generator_output_clock <= (state != ST_OFF) && (src_ext ? ext_edge : dco_pulse);
            loop_output_clock      <= engaged && locked && dco_pulse;
            ext_reference_clock    <= ext_valid && ext_edge;
        end
    end

    // fixed clock: one pending reference edge, released on a bus enable, never two in a row
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff_pending        <= 1'b0;
            ff_last           <= 1'b0;
            fixed_freq_clock  <= 1'b0;
            fixed_freq_enable <= 1'b0;
        end else begin
            fixed_freq_enable <= (state != ST_OFF) && (state != ST_SELF);
            fixed_freq_clock  <= 1'b0;
            if (ref_edge) ff_pending <= 1'b1;
            if (div_if.en_out) begin
                ff_last <= 1'b0;
                if (ff_pending && !ff_last && fixed_freq_enable) begin
                    fixed_freq_clock <= 1'b1;
                    ff_pending       <= ref_edge;
                    ff_last          <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_local_clock <= 1'b0;
            rti_clock         <= 1'b0;
        end else begin
            debug_local_clock <= dbg_tick;
            rti_clock         <= rti_tick;
        end
    end

    a_off_static: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_OFF |=> !generator_output_clock) else $error("output moved in off mode");
    a_stop_to_off: assert property (@(posedge pclk) disable iff (!presetn)
        stop_sync |=> state == ST_OFF) else $error("stop did not enter off mode");
    a_bypass_needs_ref: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == ST_BYPASS) |-> $past(ext_valid)) else $error("bypass without valid reference");
    a_self_no_trim: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_SELF && !filter_wr |=> $stable(filter)) else $error("filter moved in self mode");
    a_ref_lost_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_LOOP_EXT && !ext_valid && !filter_wr |=> $stable(filter))
        else $error("filter moved without reference");
    a_lock_after_matches: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(locked) |-> $past(match_cnt) == LOCK_MATCHES - 3'h1) else $error("lock too early");
    a_loop_out_locked: assert property (@(posedge pclk) disable iff (!presetn)
        loop_output_clock |-> $past(locked) && $past(dco_pulse)) else $error("loop clock while unlocked");
    a_loss_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (lost_set || clk_loss_set) && rst_sel |=> loss_reset) else $error("loss reset missing");
    a_fixed_half: assert property (@(posedge pclk) disable iff (!presetn)
        fixed_freq_clock |-> $past(div_if.en_out) && !$past(ff_last)) else $error("fixed clock off bus");
    a_switch_clean: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(src_ext) |-> !$past(dco_pulse) && !$past(ext_edge)) else $error("source switched on a pulse");
endmodule : cgm_mode_ctrl

// ### design/cgm_pkg.sv
/*
  cgm_pkg: register map, field positions, reset values, mode codes and timing counts of the
  clock generator mode control.
  Assumes a single 100 MHz pclk domain; every derived clock is a one-cycle enable.
*/
// Function
// - any reset enters self-clocked mode, loop open
// - self-clocked: oscillator follows stored filter only
// - off mode holds generator output static
// - processor stop may enter off mode
// - internal loop: programmable multiple of internal reference
// - bypass mode routes external reference as source
// - external loop: programmable multiple of external reference
// - engaged modes hold unlocked while loop adjusts
// - reaching target multiple moves to locked
// - status shows lock achieved and lock lost
// - status shows external reference currently valid
// - reference or lock loss raises reset or interrupt
// - oscillator keeps frequency when reference disappears
// - filter setting retained through stop
// - bus divider selects one of eight divisors
// - non-running sources cannot be selected
// - switch to loop output once locked
// - fixed clock bus-synchronous, at most half bus rate
// - fixed-frequency enable gates fixed clock
// - 8 MHz source drives debug local clock
// - separate self-clocked source drives real-time tick
// - two-bit mode field encodes four modes
// - bypass waits for valid external reference
package cgm_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_FILTER      = 8'h04;
    localparam logic [7:0]  OFF_MULT        = 8'h08;
    localparam logic [7:0]  OFF_STATUS      = 8'h0C;
    localparam int unsigned CTRL_MODE_LSB   = 0;
    localparam int unsigned CTRL_DIV_LSB    = 2;
    localparam int unsigned CTRL_RST_SEL    = 5;
    localparam int unsigned CTRL_LOCD       = 6;
    localparam int unsigned STAT_LOCK       = 0;
    localparam int unsigned STAT_LOST       = 1;
    localparam int unsigned STAT_EXTV       = 2;
    localparam int unsigned STAT_LOSS       = 3;
    localparam int unsigned STAT_STATE_LSB  = 4;
    localparam int unsigned STAT_SRC        = 7;
    localparam logic [15:0] FILTER_RST      = 16'h1000;
    localparam logic [15:0] FILTER_STEP     = 16'h0010;
    localparam logic [9:0]  MULT_RST        = 10'h032;
    localparam logic [2:0]  DIV_RST         = 3'h0;
    localparam int unsigned INT_REF_HZ      = 243_000;
    localparam int unsigned INT_REF_DIV     = CLK_HZ / INT_REF_HZ;
    localparam int unsigned DEBUG_HZ        = 8_000_000;
    localparam int unsigned DEBUG_DIV       = CLK_HZ / DEBUG_HZ;
    localparam int unsigned RTI_HZ          = 1_000;
    localparam int unsigned RTI_DIV_DEF     = CLK_HZ / RTI_HZ;
    localparam int unsigned EXT_TIMEOUT_NS  = 5_000;
    localparam logic [9:0]  EXT_TIMEOUT_CYC = 10'(EXT_TIMEOUT_NS / CLK_PERIOD_NS);
    localparam logic [2:0]  LOCK_MATCHES    = 3'h4;
    localparam logic [15:0] LOCK_TOL        = 16'h0001;
    localparam logic [15:0] LOSS_TOL        = 16'h0004;
    typedef enum logic [1:0] {
        MODE_SELF       = 2'b00,
        MODE_LOOP_INT   = 2'b01,
        MODE_BYPASS_EXT = 2'b10,
        MODE_LOOP_EXT   = 2'b11
    } cgm_mode_t;
    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_SELF     = 3'b001,
        ST_LOOP_INT = 3'b010,
        ST_BYPASS   = 3'b011,
        ST_LOOP_EXT = 3'b100
    } cgm_state_t;
endpackage : cgm_pkg

// ### design/cgm_pow2_div.sv
/*
  cgm_pow2_div: divides the generator tick by 1, 2, 4 ... 128 as sel picks.
  Assumes tick is a one-cycle enable on pclk.
*/
`timescale 1ns/1ps
module cgm_pow2_div (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // divider link
    cgm_div_if.div    d
);
    logic [6:0] cnt;
    logic [6:0] mask;

    for (genvar i = 0; i < 7; i++) begin : g_mask
        assign mask[i] = (3'(i) < d.sel);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= '0;
            d.en_out <= 1'b0;
        end else if (d.tick) begin
            cnt      <= cnt + 1'b1;
            d.en_out <= ((cnt & mask) == mask);
        end else begin
            d.en_out <= 1'b0;
        end
    end
endmodule : cgm_pow2_div

// ### design/cgm_tick_div.sv
/*
  cgm_tick_div: fixed divider giving a one-cycle enable every DIV cycles while run is high.
  Assumes DIV of at least 2.
*/
`timescale 1ns/1ps
module cgm_tick_div #(
    parameter int unsigned DIV = 2
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control and output
    input  wire logic run,
    output logic      tick
);
    localparam int unsigned W = $clog2(DIV + 1);
    logic [W-1:0] cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == W'(DIV - 1)) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : cgm_tick_div

// ### sim/clock_generator_mode_control_test.sv
/*
  clock_generator_mode_control_test: self-checking bench for cgm_mode_ctrl.
  Assumes the design files are compiled first; the bench drives APB and both pins itself.
*/
`timescale 1ns/1ps
module clock_generator_mode_control_test;
    import cgm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, stop_req, ext_run, err;
    logic        ext_ref_in = 1'b0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, gen, bus, lpo, ext, ffc, ffe, dbg, rti, lrst, lirq;
    int          n_fail, total_checks, ecnt;
    int          g[9];

    cgm_mode_ctrl #(.RTI_DIV(20)) cgm_mode_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_ref_in(ext_ref_in), .stop_req(stop_req), .generator_output_clock(gen),
        .bus_clk_en(bus), .loop_output_clock(lpo), .ext_reference_clock(ext),
        .fixed_freq_clock(ffc), .fixed_freq_enable(ffe), .debug_local_clock(dbg),
        .rti_clock(rti), .loss_reset(lrst), .loss_irq(lirq));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // external reference: one rising edge every 10 cycles while running, low otherwise
    always @(posedge pclk) begin
        ecnt <= (ecnt == 9) ? 0 : ecnt + 1;
        ext_ref_in <= ext_run && (ecnt < 5);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] inr(input int v, input int lo, input int hi);
        return 32'(v >= lo && v <= hi);
    endfunction : inr

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int waits;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        waits = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            waits++;
            @(posedge pclk);
        end
        chk(32'(waits), 32'h0000_0000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask : rdchk

    // counts output pulses; g[6] fixed pulses not after a bus enable, g[7] ext ref, g[8] fixed
    task automatic run(input int n);
        logic pbus;
        g = '{default: 0};
        pbus = 1'b1;
        repeat (n) begin
            @(posedge pclk);
            g[0] += int'(gen);
            g[1] += int'(bus);
            g[2] += int'(dbg);
            g[3] += int'(rti);
            g[4] += int'(lpo);
            g[5] += int'(lrst);
            g[6] += int'(ffc && !pbus);
            g[7] += int'(ext);
            g[8] += int'(ffc);
            pbus = bus;
        end
    endtask : run

    task automatic t_reset();
        rdchk(OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rdchk(OFF_FILTER, 32'hffff_ffff, 32'(FILTER_RST));
        rdchk(OFF_MULT, 32'hffff_ffff, 32'(MULT_RST));
        rdchk(OFF_STATUS, 32'h0000_0070, 32'h0000_0010);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_div();
        for (int d = 0; d < 8; d++) begin
            apb(1'b1, OFF_CTRL, 32'(d) << CTRL_DIV_LSB);
            run(4096);
            chk(inr(g[1], (g[0] >> d) - 1, (g[0] >> d) + 1), 32'h0000_0001);
            chk(32'(g[6]), 32'h0000_0000);
            chk(32'(g[4]), 32'h0000_0000);
        end
        chk(inr(g[2], 340, 342), 32'h0000_0001);
        chk(inr(g[3], 204, 205), 32'h0000_0001);
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        $display("test divider done");
    endtask : t_div

    task automatic t_stop();
        apb(1'b1, OFF_FILTER, 32'h0000_2000);
        stop_req <= 1'b1;
        run(10);
        run(200);
        chk(32'(g[0]), 32'h0000_0000);
        rdchk(OFF_STATUS, 32'h0000_0070, 32'h0000_0000);
        stop_req <= 1'b0;
        run(10);
        rdchk(OFF_STATUS, 32'h0000_0070, 32'h0000_0010);
        rdchk(OFF_FILTER, 32'hffff_ffff, 32'h0000_2000);
        run(800);
        chk(inr(g[0], 99, 101), 32'h0000_0001);
        $display("test stop done");
    endtask : t_stop

    task automatic t_bypass(input logic rsel);
        apb(1'b1, OFF_CTRL, 32'h0000_0002 | (32'(rsel) << CTRL_RST_SEL));
        run(20);
        rdchk(OFF_STATUS, 32'h0000_0070, 32'h0000_0010);
        ext_run <= 1'b1;
        run(100);
        rdchk(OFF_STATUS, 32'h0000_00f4, 32'h0000_00b4);
        run(1000);
        chk(inr(g[0], 99, 101), 32'h0000_0001);
        chk(32'(ffe), 32'h0000_0001);
        chk(inr(g[7], 99, 101), 32'h0000_0001);
        chk(32'(g[6]), 32'h0000_0000);
        ext_run <= 1'b0;
        run(700);
        chk(32'(g[5]), 32'(rsel));
        chk(32'(lirq), 32'(!rsel));
        rdchk(OFF_STATUS, 32'h0000_007c, 32'h0000_0018);
        apb(1'b1, OFF_STATUS, 32'h0000_000a);
        run(3);
        chk(32'(lirq), 32'h0000_0000);
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_loop();
        apb(1'b1, OFF_FILTER, 32'(int'(MULT_RST) * 65536 / INT_REF_DIV));
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        rdchk(OFF_STATUS, 32'h0000_0071, 32'h0000_0020);
        for (int i = 0; i < 8000; i++) begin
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            if (rd[STAT_LOCK] === 1'b1) break;
        end
        chk(rd & 32'h0000_0071, 32'h0000_0021);
        chk(32'(ffe), 32'h0000_0001);
        run(10 * INT_REF_DIV);
        chk(inr(g[4], 10 * MULT_RST - 20, 10 * MULT_RST + 20), 32'h0000_0001);
        chk(32'(g[6]), 32'h0000_0000);
        chk(inr(g[8], 9, 11), 32'h0000_0001);
        $display("test loop done");
    endtask : t_loop

    task automatic t_ext();
        logic [31:0] f;
        ext_run <= 1'b1;
        apb(1'b1, OFF_MULT, 32'h0000_0005);
        apb(1'b1, OFF_FILTER, 32'h0000_8000);
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        run(200);
        rdchk(OFF_STATUS, 32'h0000_0075, 32'h0000_0045);
        apb(1'b0, OFF_FILTER, 32'h0000_0000);
        f = rd;
        ext_run <= 1'b0;
        run(700);
        chk(32'(lirq), 32'h0000_0001);
        rdchk(OFF_STATUS, 32'h0000_007c, 32'h0000_0048);
        rdchk(OFF_FILTER, 32'hffff_ffff, f);
        run(100);
        chk(inr(g[0], 49, 51), 32'h0000_0001);
        $display("test ext loop done");
    endtask : t_ext

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        #900_000;
        n_fail++;
        close_out();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        stop_req = 1'b0;
        ext_run = 1'b0;
        ecnt = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_div();
        t_stop();
        t_bypass(1'b0);
        t_bypass(1'b1);
        t_loop();
        t_ext();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        close_out();
    end
endmodule : clock_generator_mode_control_test
